/* logic/dhrc_chan.sv */
/*
 * Memory pointer and block size counter of one full-address channel.
 * Assumes writes and steps arrive from the control block on sys_clk.
 */
`include "dhrc_consts.svh"

module dhrc_chan (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Control side
	dhrc_chan_if.chan cif
);
	import dhrc_pkg::*;

	logic [23:0] mp_ff;
	logic [23:0] nxt_mp;
	logic [7:0] bcnt_ff;
	logic [7:0] nxt_bcnt;
	logic [7:0] binit_ff;

	// Lanes land as separate byte writes; the top lane is not stored
	function automatic logic [23:0] dhrc_merge(input logic [23:0] old, input logic [31:0] d, input logic [3:0] we);
		logic [23:0] r;
		r = old;
		for (int i = 0; i < `DHRC_BYTE_LANES; i++) begin
			if (we[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : dhrc_merge

	always_comb begin
		nxt_mp = mp_ff;
		if (cif.step) begin
			nxt_mp = mp_ff + (cif.word ? `DHRC_STEP_WORD : `DHRC_STEP_BYTE);
			// 1-Mbyte mode wraps the low 20 bits and leaves the ignored top bits alone
			if (!cif.mode16) begin
				nxt_mp = (nxt_mp & `DHRC_MP_MASK_1M) | (mp_ff & ~`DHRC_MP_MASK_1M);
			end
		end else if (|cif.mp_we) begin
			nxt_mp = dhrc_merge(mp_ff, cif.wdata, cif.mp_we);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mp_ff <= 24'h000000;
		end else begin
			mp_ff <= nxt_mp;
		end
	end

	// Block end reloads; a cut block keeps its partial count
	always_comb begin
		nxt_bcnt = bcnt_ff;
		if (cif.step) begin
			nxt_bcnt = (cif.block && cif.last) ? binit_ff : bcnt_ff - `DHRC_BLK_LAST;
		end else if (cif.blk_we) begin
			nxt_bcnt = cif.wdata[7:0];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bcnt_ff <= 8'h00;
			binit_ff <= 8'h00;
		end else begin
			bcnt_ff <= nxt_bcnt;
			if (cif.blk_we && !cif.step) begin
				binit_ff <= cif.wdata[7:0];
			end
		end
	end

	assign cif.mp = mp_ff;
	assign cif.bcnt = bcnt_ff;
	assign cif.binit = binit_ff;
	assign cif.last = (bcnt_ff == `DHRC_BLK_LAST);
endmodule : dhrc_chan

/* logic/dhrc_chan_if.sv */
/*
 * Carrier between the control block and its pointer and counter store.
 * Assumes both ends run on the same clock.
 */
interface dhrc_chan_if;
	logic [3:0] mp_we;
	logic [31:0] wdata;
	logic blk_we;
	logic step;
	logic word;
	logic mode16;
	logic block;
	logic [23:0] mp;
	logic [7:0] bcnt;
	logic [7:0] binit;
	logic last;

	modport ctl (output mp_we, wdata, blk_we, step, word, mode16, block, input mp, bcnt, binit, last);
	modport chan (input mp_we, wdata, blk_we, step, word, mode16, block, output mp, bcnt, binit, last);
endinterface : dhrc_chan_if

/* logic/dhrc_consts.svh */
/*
 * Register offsets, field positions and fixed values of the halt and resume control.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DHRC_CONSTS_SVH
`define DHRC_CONSTS_SVH

`define DHRC_OFF_MP 8'h00
`define DHRC_OFF_MP_ALIAS 8'h04
`define DHRC_OFF_IOP 8'h08
`define DHRC_OFF_BLK 8'h0C
`define DHRC_OFF_CTLA 8'h10
`define DHRC_OFF_CTLB 8'h14
`define DHRC_OFF_STAT 8'h18

`define DHRC_A_TE 0
`define DHRC_A_ME 1
`define DHRC_A_BLOCK 2
`define DHRC_A_WORD 3
`define DHRC_A_MODE16 4
`define DHRC_A_IO2MEM 5
`define DHRC_B_FAM 0
`define DHRC_B_SRC_ADC 1

`define DHRC_RESP_OK 2'h0
`define DHRC_RESP_ERR 2'h2
`define DHRC_IO_HI_1M 16'h0FFF
`define DHRC_IO_HI_16M 16'hFFFF
`define DHRC_MP_MASK_1M 24'h0FFFFF
`define DHRC_MP_MASK_16M 24'hFFFFFF
`define DHRC_STEP_BYTE 24'h000001
`define DHRC_STEP_WORD 24'h000002
`define DHRC_BLK_LAST 8'h01
`define DHRC_BYTE_LANES 3

`endif

/* logic/dhrc_pkg.sv */
/*
 * Types shared by the halt and resume control.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dhrc_pkg;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_xfer = 2'b01,
		st_next = 2'b10,
		st_dead = 2'b11
	} dhrc_state_t;
endpackage : dhrc_pkg

/* logic/dhrc_top.sv */
/*
 * Halt, abort and resume control of one full-address transfer channel, with an AXI4-Lite register slave.
 * Assumes activation requests and bus acknowledge on sys_clk; the NMI pin is asynchronous.
 */
// The AXI4-Lite register port and the register offsets were left to the implementer.
`include "dhrc_consts.svh"

module dhrc_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Activation sources and NMI
	input wire logic act_irq,
	input wire logic adc_scan_end,
	input wire logic nmi_n,
	output logic cpu_irq,
	output logic act_flag_clr,
	// Transfer bus
	output logic bus_req,
	output logic [23:0] bus_mem_addr,
	output logic [23:0] bus_io_addr,
	output logic bus_word,
	output logic bus_io_to_mem,
	input wire logic bus_ack,
	output logic dead_cycle
);
	import dhrc_pkg::*;

	dhrc_chan_if cif ();

	dhrc_state_t st_ff;
	logic [7:0] ctla_ff;
	logic [1:0] ctlb_ff;
	logic [7:0] io_ptr_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic awready_ff;
	logic wready_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic nmi_s1_ff;
	logic nmi_s2_ff;
	logic nmi_s3_ff;
	logic act_prev_ff;
	logic pend_ff;
	logic cpu_irq_ff;
	logic flag_clr_ff;
	logic bus_req_ff;
	logic [23:0] mem_addr_ff;
	logic [23:0] io_addr_ff;
	logic word_ff;
	logic io2mem_ff;
	logic dead_ff;
	logic wr_fire;
	logic wr_ctla;
	logic nmi_fall;
	logic act_lvl;
	logic req_edge;
	logic te;
	logic me;
	logic fam;
	logic run;
	logic mid;
	logic take;
	logic ack_step;

	////////////////////////////////////////////////////////////////////////////////
	// Channel store

	dhrc_chan u_chan (
		.sys_clk(sys_clk),
		.rst(rst),
		.cif(cif)
	);

	assign te = ctla_ff[`DHRC_A_TE];
	assign me = ctla_ff[`DHRC_A_ME];
	assign fam = ctlb_ff[`DHRC_B_FAM];
	assign run = te && me && fam;
	assign mid = (cif.bcnt != cif.binit);
	assign ack_step = (st_ff == st_xfer) && bus_ack;
	assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
	assign wr_ctla = wr_fire && (aw_addr_ff == `DHRC_OFF_CTLA) && w_strb_ff[0];

	assign cif.mp_we = (wr_fire && (aw_addr_ff == `DHRC_OFF_MP || aw_addr_ff == `DHRC_OFF_MP_ALIAS))
		? w_strb_ff : 4'h0;
	assign cif.wdata = w_data_ff;
	assign cif.blk_we = wr_fire && (aw_addr_ff == `DHRC_OFF_BLK) && w_strb_ff[0];
	assign cif.step = ack_step;
	assign cif.word = ctla_ff[`DHRC_A_WORD];
	assign cif.mode16 = ctla_ff[`DHRC_A_MODE16];
	assign cif.block = ctla_ff[`DHRC_A_BLOCK];

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			aw_addr_ff <= 8'h00;
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_ff) begin
				awready_ff <= 1'b0;
				aw_addr_ff <= s_axi_awaddr;
			end else if (wr_fire) begin
				awready_ff <= 1'b1;
			end
			if (s_axi_wvalid && wready_ff) begin
				wready_ff <= 1'b0;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end else if (wr_fire) begin
				wready_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `DHRC_RESP_OK;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			if (aw_addr_ff == `DHRC_OFF_MP || aw_addr_ff == `DHRC_OFF_MP_ALIAS) begin
				bresp_ff <= `DHRC_RESP_OK;
			end else if (aw_addr_ff == `DHRC_OFF_IOP || aw_addr_ff == `DHRC_OFF_BLK) begin
				bresp_ff <= `DHRC_RESP_OK;
			end else if (aw_addr_ff == `DHRC_OFF_CTLA || aw_addr_ff == `DHRC_OFF_CTLB) begin
				bresp_ff <= `DHRC_RESP_OK;
			end else if (aw_addr_ff == `DHRC_OFF_STAT) begin
				bresp_ff <= `DHRC_RESP_OK;
			end else begin
				bresp_ff <= `DHRC_RESP_ERR;
			end
		end else if (bvalid_ff && s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control registers

	// Hardware clears win over software sets on the same edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctla_ff <= 8'h00;
		end else begin
			if (wr_ctla) begin
				ctla_ff <= w_data_ff[7:0];
			end
			if (nmi_fall && fam) begin
				ctla_ff[`DHRC_A_ME] <= 1'b0;
			end
			if (ack_step && !cif.block && cif.last) begin
				ctla_ff[`DHRC_A_TE] <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctlb_ff <= 2'h0;
			io_ptr_ff <= 8'h00;
		end else if (wr_fire && w_strb_ff[0]) begin
			if (aw_addr_ff == `DHRC_OFF_CTLB) begin
				ctlb_ff <= w_data_ff[1:0];
			end else if (aw_addr_ff == `DHRC_OFF_IOP) begin
				io_ptr_ff <= w_data_ff[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `DHRC_RESP_OK;
		end else if (s_axi_arvalid && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rresp_ff <= `DHRC_RESP_OK;
			if (s_axi_araddr == `DHRC_OFF_MP || s_axi_araddr == `DHRC_OFF_MP_ALIAS) begin
				rdata_ff <= {8'h00, cif.mp};
			end else if (s_axi_araddr == `DHRC_OFF_IOP) begin
				rdata_ff <= {24'h000000, io_ptr_ff};
			end else if (s_axi_araddr == `DHRC_OFF_BLK) begin
				rdata_ff <= {16'h0000, cif.binit, cif.bcnt};
			end else if (s_axi_araddr == `DHRC_OFF_CTLA) begin
				rdata_ff <= {24'h000000, ctla_ff};
			end else if (s_axi_araddr == `DHRC_OFF_CTLB) begin
				rdata_ff <= {30'h00000000, ctlb_ff};
			end else if (s_axi_araddr == `DHRC_OFF_STAT) begin
				rdata_ff <= {27'h0000000, mid, pend_ff, run, st_ff};
			end else begin
				rdata_ff <= 32'h00000000;
				rresp_ff <= `DHRC_RESP_ERR;
			end
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// NMI synchroniser and activation sources

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			nmi_s1_ff <= 1'b1;
			nmi_s2_ff <= 1'b1;
			nmi_s3_ff <= 1'b1;
		end else begin
			nmi_s1_ff <= nmi_n;
			nmi_s2_ff <= nmi_s1_ff;
			nmi_s3_ff <= nmi_s2_ff;
		end
	end

	assign nmi_fall = nmi_s3_ff && !nmi_s2_ff;
	assign act_lvl = ctlb_ff[`DHRC_B_SRC_ADC] ? adc_scan_end : act_irq;
	assign req_edge = act_lvl && !act_prev_ff;
	assign take = (st_ff == st_idle) && pend_ff;

	// Requests while halted are dropped, never queued
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			act_prev_ff <= 1'b0;
			pend_ff <= 1'b0;
			cpu_irq_ff <= 1'b0;
		end else begin
			act_prev_ff <= act_lvl;
			cpu_irq_ff <= act_lvl && !te;
			if (req_edge && run) begin
				pend_ff <= 1'b1;
			end else if (take) begin
				pend_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transfer sequencer

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_ff <= st_idle;
			bus_req_ff <= 1'b0;
			mem_addr_ff <= 24'h000000;
			io_addr_ff <= 24'h000000;
			word_ff <= 1'b0;
			io2mem_ff <= 1'b0;
			dead_ff <= 1'b0;
			flag_clr_ff <= 1'b0;
		end else begin
			dead_ff <= 1'b0;
			flag_clr_ff <= 1'b0;
			case (st_ff)
				st_idle: begin
					if (take && run) begin
						st_ff <= st_xfer;
						bus_req_ff <= 1'b1;
						mem_addr_ff <= cif.mp & (cif.mode16 ? `DHRC_MP_MASK_16M : `DHRC_MP_MASK_1M);
						io_addr_ff <= {cif.mode16 ? `DHRC_IO_HI_16M : `DHRC_IO_HI_1M, io_ptr_ff};
						word_ff <= cif.word;
						io2mem_ff <= ctla_ff[`DHRC_A_IO2MEM];
					end else if (take) begin
						st_ff <= st_dead;
						dead_ff <= 1'b1;
					end
				end
				st_xfer: begin
					if (bus_ack) begin
						st_ff <= st_next;
						bus_req_ff <= 1'b0;
					end
				end
				st_next: begin
					if (cif.block && mid && run) begin
						st_ff <= st_xfer;
						bus_req_ff <= 1'b1;
						mem_addr_ff <= cif.mp & (cif.mode16 ? `DHRC_MP_MASK_16M : `DHRC_MP_MASK_1M);
					end else begin
						st_ff <= st_idle;
						flag_clr_ff <= cif.block && mid;
					end
				end
				st_dead: begin
					st_ff <= st_idle;
				end
				default: begin
					st_ff <= st_idle;
				end
			endcase
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign cpu_irq = cpu_irq_ff;
	assign act_flag_clr = flag_clr_ff;
	assign bus_req = bus_req_ff;
	assign bus_mem_addr = mem_addr_ff;
	assign bus_io_addr = io_addr_ff;
	assign bus_word = word_ff;
	assign bus_io_to_mem = io2mem_ff;
	assign dead_cycle = dead_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_halted_idle;
		te && !me && !pend_ff;
	endsequence

	sequence s_cut_block;
		(st_ff == st_next) && cif.block && mid && !run;
	endsequence

	property p_halt_no_irq;
		te |=> !cpu_irq_ff;
	endproperty
	a_halt_no_irq: assert property (p_halt_no_irq) else $error("cpu interrupt while enabled");

	property p_irq_pass;
		!te && act_lvl |=> cpu_irq_ff;
	endproperty
	a_irq_pass: assert property (p_irq_pass) else $error("source not passed to cpu");

	property p_halt_drop;
		s_halted_idle |=> !pend_ff;
	endproperty
	a_halt_drop: assert property (p_halt_drop) else $error("request kept while halted");

	property p_nmi_me;
		nmi_fall && fam |=> !me;
	endproperty
	a_nmi_me: assert property (p_nmi_me) else $error("nmi left master enable set");

	property p_dead_still;
		dead_ff |=> $stable(cif.mp) && $stable(cif.bcnt);
	endproperty
	a_dead_still: assert property (p_dead_still) else $error("dead cycle moved channel");

	property p_cut_clear;
		s_cut_block |=> flag_clr_ff && !bus_req_ff ##1 !bus_req_ff;
	endproperty
	a_cut_clear: assert property (p_cut_clear) else $error("cut block not flagged");

	property p_partial;
		flag_clr_ff |-> cif.bcnt != cif.binit;
	endproperty
	a_partial: assert property (p_partial) else $error("partial count lost");

	property p_io_range;
		bus_req_ff |-> io_addr_ff[23:8] == `DHRC_IO_HI_16M || io_addr_ff[23:8] == `DHRC_IO_HI_1M;
	endproperty
	a_io_range: assert property (p_io_range) else $error("io address out of range");

	property p_mp_1m;
		$rose(bus_req_ff) && !$past(cif.mode16) |-> mem_addr_ff[23:20] == 4'h0;
	endproperty
	a_mp_1m: assert property (p_mp_1m) else $error("1-Mbyte pointer upper bits used");

	property p_resume;
		take && run |=> bus_req_ff && st_ff == st_xfer;
	endproperty
	a_resume: assert property (p_resume) else $error("request not served");

	property p_halt_after_unit;
		ack_step && !run |=> !bus_req_ff ##1 !bus_req_ff && st_ff == st_idle;
	endproperty
	a_halt_after_unit: assert property (p_halt_after_unit) else $error("no halt after unit");
endmodule : dhrc_top

/* test/dhrc_bus_model.sv */
/*
 * Far side of the transfer bus: memory and peripherals that answer each unit.
 * Assumes bus_req and its qualifiers are held by the design until bus_ack is seen.
 */
module dhrc_bus_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Transfer bus
	input wire logic bus_req,
	input wire logic [3:0] lat,
	output logic bus_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_ff;

	////////////////////////////////////////////////////////////////
	// One-cycle acknowledge after lat waiting cycles
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bus_ack <= 1'b0;
			wait_ff <= 4'h0;
		end else if (bus_ack) begin
			bus_ack <= 1'b0;
			wait_ff <= 4'h0;
		end else if (bus_req) begin
			if (wait_ff >= lat)
				bus_ack <= 1'b1;
			else
				wait_ff <= wait_ff + 4'h1;
		end
	end
endmodule : dhrc_bus_model

/* test/tb.sv */
/*
 * Self-checking bench: AXI4-Lite register tasks, halt and resume sequences.
 * Assumes the design files and dhrc_bus_model are compiled first.
 */
`include "dhrc_consts.svh"
`define TB_CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
	$display("wrong value %s expected %h seen %h", nm, exp, got); end end

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] te_b = 32'h1 << `DHRC_A_TE;
	localparam logic [31:0] me_b = 32'h1 << `DHRC_A_ME;
	localparam logic [31:0] blk_w = (32'h1 << `DHRC_A_BLOCK) | (32'h1 << `DHRC_A_WORD);
	localparam logic [31:0] m16_b = 32'h1 << `DHRC_A_MODE16;
	logic sys_clk = 1'b0, rst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0, lat = 4'h8;
	logic [1:0] bresp, rresp;
	logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
	logic act_irq = 1'b0, adc_scan_end = 1'b0, nmi_n = 1'b1;
	logic cpu_irq, act_flag_clr, bus_req, bus_word, bus_io_to_mem, bus_ack, dead_cycle;
	logic [23:0] bus_mem_addr, bus_io_addr;
	int n_errors = 0, n_checks = 0, acks = 0, clrs = 0, irqs = 0, deads = 0, a0;

	always #10 sys_clk = ~sys_clk;

	dhrc_top dut (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .act_irq(act_irq),
		.adc_scan_end(adc_scan_end), .nmi_n(nmi_n), .cpu_irq(cpu_irq), .act_flag_clr(act_flag_clr),
		.bus_req(bus_req), .bus_mem_addr(bus_mem_addr), .bus_io_addr(bus_io_addr), .bus_word(bus_word),
		.bus_io_to_mem(bus_io_to_mem), .bus_ack(bus_ack), .dead_cycle(dead_cycle));

	dhrc_bus_model mem (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .lat(lat), .bus_ack(bus_ack));

	////////////////////////////////////////////////////////////////
	// Event counters seen at each edge
	always @(posedge sys_clk) begin
		if (bus_ack && bus_req)
			acks++;
		if (act_flag_clr)
			clrs++;
		if (cpu_irq)
			irqs++;
		if (dead_cycle)
			deads++;
	end

	////////////////////////////////////////////////////////////////
	// Register access
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		bit aw_p, w_p;
		aw_p = 1;
		w_p = 1;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (aw_p && awready) begin
				aw_p = 0;
				awvalid <= 1'b0;
			end
			if (w_p && wready) begin
				w_p = 0;
				wvalid <= 1'b0;
			end
		end while (aw_p || w_p || !bvalid);
		bready <= 1'b0;
		`TB_CHK("bresp", er, bresp)
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		bit ar_p;
		ar_p = 1;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (ar_p && arready) begin
				ar_p = 0;
				arvalid <= 1'b0;
			end
		end while (ar_p || !rvalid);
		rready <= 1'b0;
		`TB_CHK("rdata", e, rdata)
		`TB_CHK("rresp", er, rresp)
	endtask : rd

	task automatic pulse(input bit adc);
		@(posedge sys_clk);
		if (adc)
			adc_scan_end <= 1'b1;
		else
			act_irq <= 1'b1;
		@(posedge sys_clk);
		adc_scan_end <= 1'b0;
		act_irq <= 1'b0;
	endtask : pulse

	task automatic results;
		if (n_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_errors++;
		results();
	end

	////////////////////////////////////////////////////////////////
	// Tests
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(`DHRC_OFF_STAT, 32'h0, `DHRC_RESP_OK);
		rd(`DHRC_OFF_CTLA, 32'h0, `DHRC_RESP_OK);
		rd(8'h1C, 32'h0, `DHRC_RESP_ERR);
		wr(8'h1C, 32'hFFFFFFFF, 4'hF, `DHRC_RESP_ERR);
		wr(`DHRC_OFF_MP, 32'hFFFFFFFE, 4'hF, `DHRC_RESP_OK);
		rd(`DHRC_OFF_MP, 32'h00FFFFFE, `DHRC_RESP_OK);
		wr(`DHRC_OFF_MP_ALIAS, 32'h00123456, 4'h1, `DHRC_RESP_OK);
		rd(`DHRC_OFF_MP, 32'h00FFFF56, `DHRC_RESP_OK);
		wr(`DHRC_OFF_MP_ALIAS, 32'hAA123400, 4'hE, `DHRC_RESP_OK);
		rd(`DHRC_OFF_MP, 32'h00123456, `DHRC_RESP_OK);
		wr(`DHRC_OFF_IOP, 32'h10, 4'h1, `DHRC_RESP_OK);
		wr(`DHRC_OFF_BLK, 32'h3, 4'h1, `DHRC_RESP_OK);
		rd(`DHRC_OFF_BLK, 32'h0303, `DHRC_RESP_OK);
		wr(`DHRC_OFF_CTLB, 32'h1 << `DHRC_B_FAM, 4'h1, `DHRC_RESP_OK);
		wr(`DHRC_OFF_CTLA, te_b | me_b | blk_w, 4'h1, `DHRC_RESP_OK);
		pulse(0);
		do @(posedge sys_clk); while (!bus_req);
		`TB_CHK("mem_addr", 24'h023456, bus_mem_addr)
		`TB_CHK("io_addr", {`DHRC_IO_HI_1M, 8'h10}, bus_io_addr)
		`TB_CHK("word", 1'b1, bus_word)
		`TB_CHK("io2mem", 1'b0, bus_io_to_mem)
		nmi_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		nmi_n <= 1'b1;
		repeat (30) @(posedge sys_clk);
		`TB_CHK("acks", 1, acks)
		rd(`DHRC_OFF_CTLA, te_b | blk_w, `DHRC_RESP_OK);
		rd(`DHRC_OFF_BLK, 32'h0302, `DHRC_RESP_OK);
		rd(`DHRC_OFF_MP, 32'h00123458, `DHRC_RESP_OK);
		`TB_CHK("flag_clr", 1, clrs)
		pulse(0);
		repeat (8) @(posedge sys_clk);
		`TB_CHK("acks", 1, acks)
		`TB_CHK("cpu_irq", 0, irqs)
		rd(`DHRC_OFF_STAT, 32'h10, `DHRC_RESP_OK);
		lat <= 4'h1;
		wr(`DHRC_OFF_CTLA, te_b | me_b | blk_w, 4'h1, `DHRC_RESP_OK);
		repeat (8) @(posedge sys_clk);
		`TB_CHK("acks", 1, acks)
		pulse(0);
		repeat (40) @(posedge sys_clk);
		`TB_CHK("acks", 3, acks)
		rd(`DHRC_OFF_BLK, 32'h0303, `DHRC_RESP_OK);
		rd(`DHRC_OFF_MP, 32'h0012345C, `DHRC_RESP_OK);
		wr(`DHRC_OFF_CTLB, (32'h1 << `DHRC_B_FAM) | (32'h1 << `DHRC_B_SRC_ADC), 4'h1, `DHRC_RESP_OK);
		pulse(0);
		repeat (10) @(posedge sys_clk);
		`TB_CHK("acks", 3, acks)
		pulse(1);
		repeat (40) @(posedge sys_clk);
		`TB_CHK("acks", 6, acks)
		rd(`DHRC_OFF_MP, 32'h00123462, `DHRC_RESP_OK);
		wr(`DHRC_OFF_CTLA, te_b | me_b | blk_w | m16_b, 4'h1, `DHRC_RESP_OK);
		lat <= 4'h8;
		pulse(1);
		do @(posedge sys_clk); while (!bus_req);
		`TB_CHK("mem_addr", 24'h123462, bus_mem_addr)
		`TB_CHK("io_addr", {`DHRC_IO_HI_16M, 8'h10}, bus_io_addr)
		wr(`DHRC_OFF_CTLA, me_b | blk_w | m16_b, 4'h1, `DHRC_RESP_OK);
		repeat (30) @(posedge sys_clk);
		`TB_CHK("acks", 7, acks)
		rd(`DHRC_OFF_MP, 32'h00123464, `DHRC_RESP_OK);
		`TB_CHK("flag_clr", 2, clrs)
		`TB_CHK("cpu_irq", 0, irqs)
		pulse(1);
		repeat (4) @(posedge sys_clk);
		`TB_CHK("cpu_irq", 1, irqs)
		wr(`DHRC_OFF_CTLA, te_b | me_b | blk_w, 4'h1, `DHRC_RESP_OK);
		repeat (60) @(posedge sys_clk);
		a0 = acks;
		// Source edge sampled on the same edge that clears transfer enable
		fork
			wr(`DHRC_OFF_CTLA, me_b | blk_w, 4'h1, `DHRC_RESP_OK);
			begin
				repeat (2) @(posedge sys_clk);
				adc_scan_end <= 1'b1;
			end
		join
		adc_scan_end <= 1'b0;
		repeat (30) @(posedge sys_clk);
		`TB_CHK("dead", 1, deads)
		`TB_CHK("acks", a0, acks)
		rd(`DHRC_OFF_MP, 32'h00123464, `DHRC_RESP_OK);
		rd(`DHRC_OFF_BLK, 32'h0302, `DHRC_RESP_OK);
		results();
	end
endmodule : tb
